// [fwq_pkg.sv]
`default_nettype none
package fwq_pkg;
    // pin and user widths
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int QADDR_HI = 6;              // last address bit allowed set

    // clock and bus timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_WP_NS  = 35;              // write pulse low, least
    localparam int T_WPH_NS = 20;              // write pulse high, least
    localparam int T_ACC_NS = 70;              // read access, least wait
    localparam logic [3:0] WP_CYC =
        4'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] WPH_CYC =
        4'((T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] ACC_CYC =
        4'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // command words
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [ADDR_W-1:0] QUERY_ADDR_WORD = 22'h000055;
    localparam logic [ADDR_W-1:0] QUERY_ADDR_BYTE = 22'h0000aa;

    // query table word offsets
    localparam logic [6:0] Q_SIG0     = 7'h10;
    localparam logic [6:0] Q_CMDSET   = 7'h13;
    localparam logic [6:0] Q_EXTPTR   = 7'h15;
    localparam logic [6:0] Q_ALT_LO   = 7'h17;
    localparam logic [6:0] Q_ALT_HI   = 7'h1a;
    localparam logic [6:0] Q_VCC_MIN  = 7'h1b;
    localparam logic [6:0] Q_VCC_MAX  = 7'h1c;
    localparam logic [6:0] Q_TO_WORD  = 7'h1f;
    localparam logic [6:0] Q_TO_BLK   = 7'h21;
    localparam logic [6:0] Q_MX_WORD  = 7'h23;
    localparam logic [6:0] Q_MX_BLK   = 7'h25;
    localparam logic [6:0] Q_TO_LAST  = 7'h26;

    // user operations
    typedef enum logic [2:0] {
        FWQ_OP_WRITE,
        FWQ_OP_READ,
        FWQ_OP_QENTER,
        FWQ_OP_QEXIT,
        FWQ_OP_QREAD
    } fwq_op_t;

    // device mode as tracked by the host
    typedef enum logic [1:0] {
        FWQ_MODE_ARRAY,
        FWQ_MODE_AUTOSEL,
        FWQ_MODE_QUERY
    } fwq_mode_t;

    typedef struct packed {
        fwq_op_t             op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   data;
    } fwq_req_t;

    typedef struct packed {
        logic                ce_n;
        logic                we_n;
        logic                oe_n;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   dq_o;
        logic                dq_oe;
        logic                hv_reset;
        logic                wp_accel;
    } fwq_pins_t;
endpackage
`default_nettype wire

// [fwq_host.sv]
`default_nettype none
// Functional notes
// - write needs ce, we low, oe high
// - query entry: 98h at 55h or AAh
// - word-mode query reads keep A7 up zero
// - reset command leaves query to array
// - query from autoselect returns to autoselect
module fwq_host
    import fwq_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // user request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire fwq_req_t          req,
    // user answer
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    // user controls and status
    input  wire logic              byte_mode,
    input  wire logic              autoselect_active,
    input  wire logic              unprotect_req,
    input  wire logic              write_protect_req,
    output fwq_mode_t              mode,
    // flash pins
    output fwq_pins_t              pins,
    input  wire logic [DATA_W-1:0] dq_i
);
    typedef enum logic [2:0] {
        S_IDLE,
        S_SETUP,
        S_WLOW,
        S_WHIGH,
        S_READ
    } fwq_state_t;

    typedef struct packed {
        fwq_state_t          st;
        logic [3:0]          cnt;
        fwq_op_t             op;
        logic                bm;
        logic                ret_auto;
        fwq_mode_t           mode;
        logic                rsp_valid;
        logic [DATA_W-1:0]   rsp_data;
        fwq_pins_t           pins;
    } fwq_regs_t;

    fwq_regs_t r;
    fwq_regs_t next_r;

    // requests only taken between bus cycles
    assign req_ready = (r.st == S_IDLE);
    assign rsp_valid = r.rsp_valid;
    assign rsp_data  = r.rsp_data;
    assign mode      = r.mode;
    assign pins      = r.pins;

    // next state of the bus sequencer
    always_comb begin
        next_r = r;
        next_r.rsp_valid = 1'b0;
        next_r.pins.hv_reset = unprotect_req;
        next_r.pins.wp_accel = ~write_protect_req;
        case (r.st)
            S_IDLE: begin
                if (req_valid) begin
                    next_r.op   = req.op;
                    next_r.bm   = byte_mode;
                    next_r.cnt  = 4'h0;
                    next_r.pins.ce_n = 1'b0;
                    next_r.pins.oe_n = 1'b1;
                    next_r.pins.addr = req.addr;
                    next_r.pins.dq_o = req.data;
                    case (req.op)
                        FWQ_OP_QENTER: begin
                            next_r.pins.addr = byte_mode ?
                                QUERY_ADDR_BYTE : QUERY_ADDR_WORD;
                            next_r.pins.dq_o = {8'h00, CMD_QUERY};
                        end
                        FWQ_OP_QEXIT: begin
                            next_r.pins.dq_o = {8'h00, CMD_RESET};
                        end
                        FWQ_OP_QREAD: begin
                            // table offset only, upper bits forced zero
                            next_r.pins.addr = byte_mode ?
                                {14'h0000, req.addr[QADDR_HI:0], 1'b0} :
                                {15'h0000, req.addr[QADDR_HI:0]};
                        end
                        default: begin
                        end
                    endcase
                    if (req.op == FWQ_OP_READ || req.op == FWQ_OP_QREAD) begin
                        next_r.pins.oe_n  = 1'b0;
                        next_r.pins.dq_oe = 1'b0;
                        next_r.st = S_READ;
                    end else begin
                        next_r.pins.dq_oe = 1'b1;
                        next_r.st = S_SETUP;
                    end
                end
            end
            S_SETUP: begin
                // address settles before the later falling strobe
                next_r.pins.we_n = 1'b0;
                next_r.cnt = 4'h1;
                next_r.st  = S_WLOW;
            end
            S_WLOW: begin
                if (r.cnt >= WP_CYC) begin
                    next_r.pins.we_n = 1'b1;
                    next_r.cnt = 4'h1;
                    next_r.st  = S_WHIGH;
                end else begin
                    next_r.cnt = r.cnt + 4'h1;
                end
            end
            S_WHIGH: begin
                if (r.cnt >= WPH_CYC) begin
                    next_r.pins.ce_n  = 1'b1;
                    next_r.pins.dq_oe = 1'b0;
                    next_r.rsp_valid  = 1'b1;
                    next_r.rsp_data   = r.pins.dq_o;
                    next_r.st = S_IDLE;
                    if (r.op == FWQ_OP_QENTER) begin
                        next_r.ret_auto = (r.mode == FWQ_MODE_AUTOSEL);
                        next_r.mode = FWQ_MODE_QUERY;
                    end else if (r.op == FWQ_OP_QEXIT) begin
                        next_r.mode = r.ret_auto ?
                            FWQ_MODE_AUTOSEL : FWQ_MODE_ARRAY;
                    end else if (r.mode == FWQ_MODE_QUERY) begin
                        // a stray word closes the table, back to array
                        next_r.mode = FWQ_MODE_ARRAY;
                    end else begin
                        // outside query the device follows the user flag
                        next_r.mode = autoselect_active ?
                            FWQ_MODE_AUTOSEL : FWQ_MODE_ARRAY;
                    end
                end else begin
                    next_r.cnt = r.cnt + 4'h1;
                end
            end
            S_READ: begin
                if (r.cnt >= ACC_CYC) begin
                    next_r.pins.ce_n = 1'b1;
                    next_r.pins.oe_n = 1'b1;
                    next_r.rsp_valid = 1'b1;
                    next_r.rsp_data  = dq_i;
                    next_r.st = S_IDLE;
                end else begin
                    next_r.cnt = r.cnt + 4'h1;
                end
            end
            default: begin
                next_r.st = S_IDLE;
            end
        endcase
        if (r.st == S_IDLE && !req_valid && r.mode != FWQ_MODE_QUERY) begin
            next_r.mode = autoselect_active ?
                FWQ_MODE_AUTOSEL : FWQ_MODE_ARRAY;
        end
    end

    // state register; strobes idle high from reset on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= S_IDLE;
            r.op <= FWQ_OP_READ;
            r.mode <= FWQ_MODE_ARRAY;
            r.pins.ce_n <= 1'b1;
            r.pins.we_n <= 1'b1;
            r.pins.oe_n <= 1'b1;
            r.pins.wp_accel <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // write strobe only with chip enabled and output disabled
    property p_write_strobes;
        @(posedge clk) disable iff (!rst_n)
        !r.pins.we_n |-> (!r.pins.ce_n && r.pins.oe_n && r.pins.dq_oe);
    endproperty
    a_write_strobes: assert property (p_write_strobes)
        else $error("write strobe without valid ce or oe");

    // write pulse holds low for its full width
    property p_we_width;
        @(posedge clk) disable iff (!rst_n)
        $fell(r.pins.we_n) |-> (!r.pins.we_n)[*7];
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write pulse too short");

    // query entry writes the query code at the mode address
    property p_qenter_cmd;
        @(posedge clk) disable iff (!rst_n)
        (!r.pins.we_n && r.op == FWQ_OP_QENTER) |->
            (r.pins.dq_o[7:0] == 8'h98) &&
            (r.pins.addr == (r.bm ? 22'h0000aa : 22'h000055));
    endproperty
    a_qenter_cmd: assert property (p_qenter_cmd)
        else $error("bad query entry cycle");

    // word-mode query reads keep high address bits zero
    property p_query_addr;
        @(posedge clk) disable iff (!rst_n)
        (r.st == S_READ && r.op == FWQ_OP_QREAD && !r.bm) |->
            (r.pins.addr[ADDR_W-1:7] == '0);
    endproperty
    a_query_addr: assert property (p_query_addr)
        else $error("query read with high address bits set");

    // query exit leaves query mode when the reset write ends
    property p_qexit_mode;
        @(posedge clk) disable iff (!rst_n)
        (r.rsp_valid && r.op == FWQ_OP_QEXIT && !r.ret_auto) |->
            (r.mode == FWQ_MODE_ARRAY) && (r.rsp_data[7:0] == 8'hf0);
    endproperty
    a_qexit_mode: assert property (p_qexit_mode)
        else $error("query exit did not return to array");

    // query entered from autoselect goes back to autoselect
    property p_qexit_auto;
        @(posedge clk) disable iff (!rst_n)
        (r.rsp_valid && r.op == FWQ_OP_QEXIT && r.ret_auto) |->
            (r.mode == FWQ_MODE_AUTOSEL);
    endproperty
    a_qexit_auto: assert property (p_qexit_auto)
        else $error("query exit lost autoselect");

    // read answer arrives after the full access wait
    property p_read_time;
        @(posedge clk) disable iff (!rst_n)
        $fell(r.pins.oe_n) |-> ##15 r.rsp_valid;
    endproperty
    a_read_time: assert property (p_read_time)
        else $error("read answer timing wrong");
endmodule
`default_nettype wire

// [fwq_flash_model.sv]
`default_nettype none
module fwq_flash_model
    import fwq_pkg::*;
(
    // host pins
    input  wire fwq_pins_t    pins,
    input  wire logic         byte_mode,
    // read data
    output logic [DATA_W-1:0] dq,
    // sector guard: bit 1 protected sectors open, bit 0 boot pair locked
    output logic [1:0]        guard
);
    timeunit 1ns;
    timeprecision 1ps;
    logic              query = 1'b0;
    logic              armed = 1'b0;
    logic [ADDR_W-1:0] wa = '0;
    logic [DATA_W-1:0] last = '0;
    // table words, zero where unlisted
    function automatic logic [7:0] cfi(input logic [6:0] o);
        case (o)
            7'h10: cfi = 8'h51;
            7'h11: cfi = 8'h52;
            7'h12: cfi = 8'h59;
            7'h13: cfi = 8'h02;
            7'h15: cfi = 8'h40;
            7'h1b: cfi = 8'h27;
            7'h1c: cfi = 8'h36;
            7'h1f: cfi = 8'h04;
            7'h21: cfi = 8'h0a;
            7'h23: cfi = 8'h05;
            7'h25: cfi = 8'h04;
            default: cfi = 8'h00;
        endcase
    endfunction
    // temporary unprotect follows the elevated reset level
    always_comb begin
        guard[1] = pins.hv_reset;
        guard[0] = !pins.hv_reset || !pins.wp_accel;
    end
    // commands only once strobes idled after power-up
    always @(pins.ce_n, pins.we_n)
        if (pins.ce_n && pins.we_n)
            armed = 1'b1;
    // address at write strobe fall
    always @(negedge pins.we_n)
        wa = pins.addr;
    // command at write strobe rise; other words leave the table
    always @(posedge pins.we_n)
        if (armed && !pins.ce_n && pins.oe_n)
            query = pins.dq_o[7:0] == CMD_QUERY &&
                wa == (byte_mode ? QUERY_ADDR_BYTE : QUERY_ADDR_WORD);
    // remember the word last driven
    always @(dq)
        if (!pins.ce_n && !pins.oe_n)
            last = dq;
    // read path; a released bus shows the inverted last word
    always_comb
        if (pins.ce_n || pins.oe_n)
            dq = ~last;
        else if (!query)
            dq = pins.addr[15:0] ^ 16'h5a5a;
        else if ((pins.addr >> (byte_mode ? 8 : 7)) != '0)
            dq = 16'hffff;
        else
            dq = {8'h00, cfi(byte_mode ? pins.addr[7:1] : pins.addr[6:0])};
endmodule
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb
    import fwq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              req_valid = 1'b0;
    logic              byte_mode = 1'b0;
    logic              autoselect_active = 1'b0;
    logic              unprotect_req = 1'b0;
    logic              write_protect_req = 1'b0;
    logic              req_ready;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic [DATA_W-1:0] dq_i;
    logic [1:0]        guard;
    fwq_req_t          req = '0;
    fwq_mode_t         mode;
    fwq_pins_t         pins;
    int                err_total = 0;
    int                total_checks = 0;
    // offset in the upper byte, expected word in the lower
    logic [15:0]       qt [19] = '{16'h1051, 16'h1152, 16'h1259,
        16'h1302, 16'h1400, 16'h1540, 16'h1700, 16'h1a00, 16'h1b27,
        16'h1c36, 16'h1d00, 16'h1f04, 16'h2000, 16'h210a, 16'h2200,
        16'h2305, 16'h2400, 16'h2504, 16'h2600};
    fwq_host i_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .byte_mode(byte_mode),
        .autoselect_active(autoselect_active), .mode(mode),
        .unprotect_req(unprotect_req), .pins(pins), .dq_i(dq_i),
        .write_protect_req(write_protect_req));
    fwq_flash_model i_flash (.pins(pins), .byte_mode(byte_mode), .dq(dq_i),
        .guard(guard));
    // bus clock
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // word compare
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: %h vs %h", $time, g, e);
        end
    endtask
    // one host operation, bounded wait for the answer
    task automatic op(input fwq_op_t o, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
        int n;
        req = '{o, a, d};
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        chk(16'(req_ready), 16'h0000);
        for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (rsp_valid !== 1'b1) begin
            err_total++;
            complete_run();
        end
    endtask
    // array read straight after reset
    task automatic t_pwr();
        chk(16'(mode), 16'(FWQ_MODE_ARRAY));
        op(FWQ_OP_READ, 22'h001234, '0);
        chk(rsp_data, 16'h1234 ^ 16'h5a5a);
    endtask
    // word-mode entry, table walk, exit
    task automatic t_query();
        op(FWQ_OP_QENTER, '0, '0);
        chk(16'(mode), 16'(FWQ_MODE_QUERY));
        for (int i = 0; i < 19; i++) begin
            op(FWQ_OP_QREAD, 22'(qt[i][15:8]), '0);
            chk(rsp_data, {8'h00, qt[i][7:0]});
        end
        op(FWQ_OP_QREAD, 22'h3fff10, '0);
        chk(rsp_data, 16'h0051);
        op(FWQ_OP_QEXIT, '0, '0);
        chk(16'(mode), 16'(FWQ_MODE_ARRAY));
        op(FWQ_OP_QREAD, 22'h10, '0);
        chk(rsp_data, 16'h0010 ^ 16'h5a5a);
    endtask
    // byte-mode entry and doubled addresses
    task automatic t_byte();
        byte_mode = 1'b1;
        op(FWQ_OP_QENTER, '0, '0);
        op(FWQ_OP_QREAD, 22'h1f, '0);
        chk(rsp_data, 16'h0004);
        op(FWQ_OP_QEXIT, '0, '0);
        byte_mode = 1'b0;
    endtask
    // query from autoselect returns to autoselect
    task automatic t_auto();
        autoselect_active = 1'b1;
        @(posedge clk);
        #1;
        op(FWQ_OP_QENTER, '0, '0);
        op(FWQ_OP_QREAD, 22'h11, '0);
        chk(rsp_data, 16'h0052);
        op(FWQ_OP_QEXIT, '0, '0);
        chk(16'(mode), 16'(FWQ_MODE_AUTOSEL));
        autoselect_active = 1'b0;
    endtask
    // stray command words leave the table closed
    task automatic t_bad();
        op(FWQ_OP_WRITE, 22'h000056, 16'h0098);
        chk(rsp_data, 16'h0098);
        op(FWQ_OP_QREAD, 22'h10, '0);
        chk(rsp_data, 16'h0010 ^ 16'h5a5a);
        op(FWQ_OP_QENTER, '0, '0);
        op(FWQ_OP_WRITE, 22'h000055, 16'h00a5);
        chk(16'(mode), 16'(FWQ_MODE_ARRAY));
        op(FWQ_OP_QREAD, 22'h10, '0);
        chk(rsp_data, 16'h0010 ^ 16'h5a5a);
    endtask
    // elevated reset voltage and boot lock requests
    task automatic t_pins();
        unprotect_req = 1'b1;
        write_protect_req = 1'b1;
        @(posedge clk);
        #1;
        chk({14'h0, pins.hv_reset, pins.wp_accel}, 16'h0002);
        chk({14'h0, guard}, 16'h0003);
        write_protect_req = 1'b0;
        @(posedge clk);
        #1;
        chk({14'h0, guard}, 16'h0002);
        unprotect_req = 1'b0;
        @(posedge clk);
        #1;
        chk({14'h0, pins.hv_reset, pins.wp_accel}, 16'h0001);
        chk({14'h0, guard}, 16'h0001);
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_pwr();
        t_query();
        t_byte();
        t_auto();
        t_bad();
        t_pins();
        complete_run();
    end
endmodule
`default_nettype wire
